// ### include/bsrs_pkg.sv
// constants, types and lookup functions for the bridge scan and rate sequencer
package bsrs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0]  BSRS_ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  BSRS_ADDR_SETTLE  = 8'h04;
    localparam logic [7:0]  BSRS_ADDR_STATUS  = 8'h08;
    localparam logic [7:0]  BSRS_ADDR_DATA    = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int          BSRS_CTRL_RUN     = 0;
    localparam int          BSRS_CTRL_SCAN    = 1;
    localparam int          BSRS_CTRL_AZ      = 2;
    localparam int          BSRS_CTRL_GP      = 3;
    localparam int          BSRS_CTRL_EXC10   = 4;
    localparam int          BSRS_CTRL_RATE_LO = 8;
    localparam int          BSRS_CTRL_RATE_HI = 11;
    localparam logic [11:0] BSRS_CTRL_RESET   = 12'h000;

    // status register fields
    localparam int          BSRS_STAT_CH_LO    = 0;
    localparam int          BSRS_STAT_MAINS_LO = 4;
    localparam int          BSRS_STAT_SETTLING = 6;
    localparam int          BSRS_STAT_EMPTY    = 7;
    localparam int          BSRS_STAT_LEVEL_LO = 8;

    // result word fields
    localparam int          BSRS_WORD_CH_LO   = 4;
    localparam int          BSRS_WORD_DATA_LO = 8;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int          BSRS_CLK_HZ         = 125_000_000;
    localparam int          BSRS_HZ_PER_MHZ     = 1_000_000;
    localparam logic [15:0] BSRS_SETTLE_US_RST  = 16'h0190;
    localparam int          BSRS_SCAN_CHANNELS  = 4;
    localparam int          BSRS_FIFO_DEPTH     = 16;
    localparam int          BSRS_WORD_W         = 32;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        BSRS_MAINS_NONE = 2'b00,
        BSRS_MAINS_60   = 2'b01,
        BSRS_MAINS_50   = 2'b10,
        BSRS_MAINS_BOTH = 2'b11
    } bsrs_mains_t;

    typedef enum logic {
        BSRS_PH_SIGNAL = 1'b0,
        BSRS_PH_ZERO   = 1'b1
    } bsrs_phase_t;

    // sampling rate in half samples per second, so that 2.5 stays whole
    function automatic int bsrs_rate_x2(logic [3:0] sel);
        case (sel)
            4'h0:    bsrs_rate_x2 = 60000;
            4'h1:    bsrs_rate_x2 = 30000;
            4'h2:    bsrs_rate_x2 = 15000;
            4'h3:    bsrs_rate_x2 = 7500;
            4'h4:    bsrs_rate_x2 = 4000;
            4'h5:    bsrs_rate_x2 = 2000;
            4'h6:    bsrs_rate_x2 = 1000;
            4'h7:    bsrs_rate_x2 = 200;
            4'h8:    bsrs_rate_x2 = 120;
            4'h9:    bsrs_rate_x2 = 100;
            4'hA:    bsrs_rate_x2 = 60;
            4'hB:    bsrs_rate_x2 = 50;
            4'hC:    bsrs_rate_x2 = 30;
            4'hD:    bsrs_rate_x2 = 20;
            4'hE:    bsrs_rate_x2 = 10;
            default: bsrs_rate_x2 = 5;
        endcase
    endfunction

    // mains rejection offered by the decimation filter at a given rate
    function automatic bsrs_mains_t bsrs_mains_for(logic [3:0] sel);
        case (sel)
            4'h8, 4'hA, 4'hC: bsrs_mains_for = BSRS_MAINS_60;
            4'h9, 4'hB:       bsrs_mains_for = BSRS_MAINS_50;
            4'hD, 4'hE, 4'hF: bsrs_mains_for = BSRS_MAINS_BOTH;
            default:          bsrs_mains_for = BSRS_MAINS_NONE;
        endcase
    endfunction

endpackage

// ### rtl/bsrs_fifo.sv
// result fifo with valid and ready on both sides
`timescale 1ns/1ps
module bsrs_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    // fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0]    level
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0]           mem [DEPTH];
    logic [AW-1:0]              wptr_q;
    logic [AW-1:0]              rptr_q;
    logic [$clog2(DEPTH+1)-1:0] count_q;
    logic                       do_push;
    logic                       do_pop;

    assign in_ready  = (count_q != ($clog2(DEPTH+1))'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data  = mem[rptr_q];
    assign level     = count_q;
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (do_pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

// ### rtl/bsrs_sequencer.sv
// scan, settling and data rate sequencer for a multiplexed bridge converter
`timescale 1ns/1ps
//
// Summary of operation
// (RULE1) with scanning on, channels zero to three, or four to seven in the general purpose group, are converted in turn and the order wraps.
// (RULE2) every multiplexer switch starts a settling wait, 400 us after reset.
// (RULE3) software can lengthen the settling wait through its own register.
// (RULE4) one of sixteen sampling rates from 30000 down to 2.5 per second is selected.
// (RULE5) the data rate follows rate, scan and auto-zero; with neither it equals the rate.
// (RULE6) auto-zero pairs a signal and a zero conversion, so results come at about half rate.
// (RULE7) while scanning, each result moves the scan on, so each channel gets a quarter.
// (RULE8) auto-zero is never applied to the general purpose group, channels four to seven.
// (RULE9) rates 60, 30, 15 reject 60 Hz, 50 and 25 reject 50 Hz, 10, 5, 2.5 reject both.
// (RULE10) no mains rejection is reported above 60 per second, nor above 100 with auto-zero.
// (RULE11) a control bit selects 2.5 V or 10 V bridge excitation.
// (RULE12) the auto-zero chop steps on accepted samples only, so its notches track the rate.
// (RULE13) software should keep to a fixed rate of at most 100 per second for accuracy.
// (RULE14) software should keep auto-zero and remote sensing on for low-level signals.
// (RULE15) each result carries the channel in bits 7 to 4 while scanning, zero otherwise.
// (RULE16) conversions finished inside a settling wait are thrown away.
// (RULE17) a change to rate, auto-zero or scan setup restarts at channel zero and resettles.
module bsrs_sequencer
    import bsrs_pkg::*;
#(
    parameter int CLK_HZ     = BSRS_CLK_HZ,
    parameter int FIFO_DEPTH = BSRS_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // converter
    output logic             conv_start,
    input  wire logic        adc_valid,
    input  wire logic [23:0] adc_data,
    // analog front end
    output logic [2:0]       mux_sel,
    output logic             az_short,
    output logic             exc_10v
);
    localparam int CLK_MHZ = CLK_HZ / BSRS_HZ_PER_MHZ;
    localparam int LVL_W   = $clog2(FIFO_DEPTH + 1);

    if (CLK_HZ < BSRS_HZ_PER_MHZ || CLK_HZ > 1_000_000_000 ||
        CLK_HZ % BSRS_HZ_PER_MHZ != 0 || FIFO_DEPTH > 16) begin : g_bad
        $error("clock must be whole MHz up to 1 GHz and fifo depth at most 16");
    end

    // sample period in cycles; a shorter CLK_HZ shortens every wait in simulation
    function automatic logic [31:0] period_of(logic [3:0] sel);
        period_of = 32'((2 * CLK_HZ) / bsrs_rate_x2(sel));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    logic        dph_valid_q;
    logic        dph_write_q;
    logic [7:0]  dph_addr_q;
    logic        wr;
    logic        rd;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr        = dph_valid_q & dph_write_q;
    assign rd        = dph_valid_q & ~dph_write_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dph_valid_q <= 1'b0;
            dph_write_q <= 1'b0;
            dph_addr_q  <= 8'h00;
        end else if (hready) begin
            // only the low byte decodes; words above it read as zero
            dph_valid_q <= hsel & htrans[1] & (haddr[31:8] == 24'h000000);
            dph_write_q <= hwrite;
            dph_addr_q  <= haddr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic        run_q;
    logic        scan_en_q;
    logic        az_en_q;
    logic        group_gp_q;
    logic        exc_10v_q;
    logic [3:0]  rate_sel_q;
    logic [15:0] settle_us_q;
    logic [11:0] ctrl_now;
    logic        restart;

    assign ctrl_now = {rate_sel_q, 3'h0, exc_10v_q, group_gp_q, az_en_q, scan_en_q, run_q};
    assign restart  = wr & (((dph_addr_q == BSRS_ADDR_CTRL) && (hwdata[11:0] != ctrl_now)) ||
                      ((dph_addr_q == BSRS_ADDR_SETTLE) && (hwdata[15:0] != settle_us_q))); // RULE17

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            {rate_sel_q, exc_10v_q, group_gp_q, az_en_q, scan_en_q, run_q} <=
                {BSRS_CTRL_RESET[11:8], BSRS_CTRL_RESET[4:0]};
            settle_us_q <= BSRS_SETTLE_US_RST; // RULE2
        end else if (wr && dph_addr_q == BSRS_ADDR_CTRL) begin
            run_q      <= hwdata[BSRS_CTRL_RUN];
            scan_en_q  <= hwdata[BSRS_CTRL_SCAN];
            az_en_q    <= hwdata[BSRS_CTRL_AZ];
            group_gp_q <= hwdata[BSRS_CTRL_GP];
            exc_10v_q  <= hwdata[BSRS_CTRL_EXC10]; // RULE11
            rate_sel_q <= hwdata[BSRS_CTRL_RATE_HI:BSRS_CTRL_RATE_LO]; // RULE4
        end else if (wr && dph_addr_q == BSRS_ADDR_SETTLE) begin
            settle_us_q <= hwdata[15:0]; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample strobe divider, stalled while the fifo is full
    logic [31:0] div_cnt_q;
    logic        conv_start_q;
    logic        fifo_in_ready;
    logic        tick;

    assign tick       = run_q & fifo_in_ready & (div_cnt_q == 32'h00000000);
    assign conv_start = conv_start_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q    <= 32'h00000000;
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= tick & ~restart;
            if (restart) begin
                div_cnt_q <= 32'h00000000;
            end else if (tick) begin
                div_cnt_q <= period_of(rate_sel_q) - 32'h00000001; // RULE4
            end else if (run_q && fifo_in_ready && div_cnt_q != 32'h00000000) begin
                div_cnt_q <= div_cnt_q - 32'h00000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settling after a multiplexer switch
    logic [31:0] settle_cnt_q;
    logic [31:0] settle_cycles;
    logic        settling;
    logic        mux_sw;

    assign settle_cycles = 32'(settle_us_q * CLK_MHZ);
    assign settling      = (settle_cnt_q != 32'h00000000);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            settle_cnt_q <= 32'(BSRS_SETTLE_US_RST * CLK_MHZ);
        end else if (restart || mux_sw) begin
            // the new value of settle_us_q is not yet visible on restart, so take the bus word
            settle_cnt_q <= (wr && dph_addr_q == BSRS_ADDR_SETTLE) ?
                            32'(hwdata[15:0] * CLK_MHZ) : settle_cycles; // RULE2 RULE3
        end else if (settling) begin
            settle_cnt_q <= settle_cnt_q - 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion acceptance, auto-zero pairing and scan order
    bsrs_phase_t phase_q;
    logic [23:0] sig_q;
    logic [1:0]  ch_q;
    logic        az_act;
    logic        acc;
    logic        push;
    logic [23:0] result;
    logic [31:0] push_word;

    assign az_act    = az_en_q & ~group_gp_q; // RULE8
    assign acc       = adc_valid & ~settling & ~restart; // RULE16
    assign push      = acc & (~az_act | (phase_q == BSRS_PH_ZERO)); // RULE5 RULE6
    assign mux_sw    = push & scan_en_q; // RULE7
    assign result    = az_act ? (sig_q - adc_data) : adc_data;
    assign push_word = {result, (scan_en_q ? {2'b00, ch_q} : 4'h0), 4'h0}; // RULE15

    // the chop alternates on accepted samples only, so notches follow the rate
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= BSRS_PH_SIGNAL;
            sig_q   <= 24'h000000;
        end else if (restart) begin
            phase_q <= BSRS_PH_SIGNAL; // RULE17
        end else if (acc && az_act) begin
            if (phase_q == BSRS_PH_SIGNAL) begin
                sig_q   <= adc_data;
                phase_q <= BSRS_PH_ZERO; // RULE12
            end else begin
                phase_q <= BSRS_PH_SIGNAL; // RULE6
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ch_q <= 2'h0;
        end else if (restart) begin
            ch_q <= 2'h0; // RULE17
        end else if (mux_sw) begin
            ch_q <= ch_q + 2'h1; // RULE1
        end
    end

    assign mux_sel  = {group_gp_q, scan_en_q ? ch_q : 2'h0};
    assign az_short = az_act & (phase_q == BSRS_PH_ZERO); // RULE8
    assign exc_10v  = exc_10v_q; // RULE11

    ////////////////////////////////////////////////////////////////////////////
    // result fifo and read mux
    logic             fifo_out_valid;
    logic [31:0]      fifo_out_data;
    logic [LVL_W-1:0] fifo_level;
    logic             pop;
    bsrs_mains_t      mains;

    assign pop   = rd & (dph_addr_q == BSRS_ADDR_DATA);
    // with auto-zero the filter also rejects 50 Hz at 100 per second
    assign mains = (az_act && rate_sel_q == 4'h7) ?
                   BSRS_MAINS_50 : bsrs_mains_for(rate_sel_q); // RULE9 RULE10

    bsrs_fifo #(
        .WIDTH (BSRS_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_word),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    always_comb begin
        hrdata = 32'h00000000;
        if (!rd) begin
            hrdata = 32'h00000000;
        end else if (dph_addr_q == BSRS_ADDR_CTRL) begin
            hrdata[11:0] = ctrl_now;
        end else if (dph_addr_q == BSRS_ADDR_SETTLE) begin
            hrdata[15:0] = settle_us_q;
        end else if (dph_addr_q == BSRS_ADDR_STATUS) begin
            hrdata[BSRS_STAT_CH_LO +: 3]      = mux_sel;
            hrdata[BSRS_STAT_MAINS_LO +: 2]   = mains;
            hrdata[BSRS_STAT_SETTLING]        = settling;
            hrdata[BSRS_STAT_EMPTY]           = ~fifo_out_valid;
            hrdata[BSRS_STAT_LEVEL_LO +: LVL_W] = fifo_level;
        end else if (dph_addr_q == BSRS_ADDR_DATA) begin
            hrdata = fifo_out_valid ? fifo_out_data : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_scan_order: assert property (mux_sw |=> ch_q == $past(ch_q) + 2'h1) // RULE1
        else $error("scan did not step to the next channel");
    a_settle_load: assert property (mux_sw && !wr |=> settle_cnt_q == settle_cycles) // RULE2
        else $error("settling wait not loaded on switch");
    a_settle_prog: assert property (wr && dph_addr_q == BSRS_ADDR_SETTLE // RULE3
        |=> settle_us_q == $past(hwdata[15:0]))
        else $error("settling time write lost");
    a_tick_space: assert property (conv_start && period_of(rate_sel_q) > 32'h00000001 // RULE4
        && !restart |=> !conv_start)
        else $error("sample strobes too close");
    a_plain_rate: assert property (push && !az_act |-> adc_valid && !settling) // RULE5
        else $error("direct result without a conversion");
    a_az_pair: assert property (push && az_act |-> $past(phase_q) == BSRS_PH_SIGNAL // RULE6
        || $past(acc) == 1'b0)
        else $error("auto-zero result not paired");
    a_quarter: assert property (push && scan_en_q && !restart |=> mux_sel[1:0] != $past(mux_sel[1:0])) // RULE7
        else $error("scan did not move after a result");
    a_gp_no_az: assert property (group_gp_q |-> !az_short && !az_act) // RULE8
        else $error("auto-zero on general purpose group");
    a_mains_60: assert property (rate_sel_q == 4'h8 |-> mains == BSRS_MAINS_60) // RULE9
        else $error("60 per second must reject 60 Hz");
    a_fast_none: assert property (rate_sel_q < 4'h8 && !(az_act && rate_sel_q == 4'h7) // RULE10
        |-> mains == BSRS_MAINS_NONE)
        else $error("fast rate claims mains rejection");
    a_chan_field: assert property (push && !scan_en_q |-> push_word[7:4] == 4'h0) // RULE15
        else $error("channel field set without scanning");
    a_no_settle_push: assert property (settling |-> !push) // RULE16
        else $error("result kept during settling");
    a_restart_ch0: assert property (restart |=> ch_q == 2'h0 && phase_q == BSRS_PH_SIGNAL // RULE17
        && div_cnt_q == 32'h00000000)
        else $error("restart did not return to channel zero");

    c_wrap: cover property (mux_sw && ch_q == 2'h3);
    c_az_result: cover property (push && az_act);
    c_discard: cover property (adc_valid && settling);
    c_full: cover property (run_q && !fifo_in_ready);

endmodule

// ### bench/bsrs_adc_model.sv
// converter and front end model answering conversion starts
`timescale 1ns/1ps
module bsrs_adc_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // conversion handshake
    input  wire logic        conv_start,
    output logic             adc_valid,
    output logic [23:0]      adc_data,
    // front end state
    input  wire logic [2:0]  mux_sel,
    input  wire logic        az_short,
    // bench knobs
    input  wire logic [23:0] sig_base,
    input  wire logic [23:0] zero_lvl,
    input  wire logic [3:0]  lat
);
    logic [23:0] smp;
    int          cnt;

    ////////////////////////////////////////////////////////////////////////////
    // one conversion in flight; idle data toggles so a stale word never matches
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            adc_valid <= 1'b0;
            adc_data  <= 24'h5A5A5A;
            smp       <= 24'h0;
            cnt       <= 0;
        end else begin
            adc_valid <= 1'b0;
            adc_data  <= ~adc_data;
            if (conv_start) begin
                smp <= az_short ? zero_lvl : sig_base + {mux_sel, 4'h0};
                cnt <= int'(lat);
            end else if (cnt == 1) begin
                adc_valid <= 1'b1;
                adc_data  <= smp;
                cnt       <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// ### bench/tb.sv
// self-checking bench for the scan and rate sequencer
`timescale 1ns/1ps
module tb;
    import bsrs_pkg::*;
    localparam int CLK = 1_000_000;
    logic        sys_clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic        conv_start, adc_valid, az_short, exc_10v, az_seen;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [23:0] adc_data, sig_base, zero_lvl;
    logic [2:0]  hsize, mux_sel;
    logic [1:0]  htrans;
    logic [3:0]  lat;
    int          fails, checks, cyc, last_t, gap, nconv, t0;

    bsrs_sequencer #(.CLK_HZ(CLK)) bsrs_sequencer_i (.sys_clk(sys_clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .conv_start(conv_start), .adc_valid(adc_valid),
        .adc_data(adc_data), .mux_sel(mux_sel), .az_short(az_short), .exc_10v(exc_10v));
    bsrs_adc_model bsrs_adc_model_i (.sys_clk(sys_clk), .resetn(resetn),
        .conv_start(conv_start), .adc_valid(adc_valid), .adc_data(adc_data),
        .mux_sel(mux_sel), .az_short(az_short), .sig_base(sig_base),
        .zero_lvl(zero_lvl), .lat(lat));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (conv_start) begin
            gap    <= cyc - last_t;
            last_t <= cyc;
            nconv  <= nconv + 1;
        end
        if (az_short) az_seen <= 1'b1;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] mains(int s, logic az);
        if (s == 8 || s == 10 || s == 12) return 2'd1;
        if (s == 9 || s == 11 || (s == 7 && az)) return 2'd2;
        return (s > 12) ? 2'd3 : 2'd0;
    endfunction
    function automatic int spacing(int s);
        return 2 * CLK / ((s == 0) ? 60000 : 30000);
    endfunction
    function automatic logic [31:0] word(logic [23:0] v, logic [3:0] ch);
        return {v, ch, 4'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // waits for hready, bounded so a stuck slave ends the run
    task automatic wt();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wt();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wt();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, {24'h0, a}, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, {24'h0, a}, 32'h0, r);
    endtask
    task automatic wait_level(input int n);
        int k;
        logic [31:0] s;
        k = 0;
        do begin
            rd(BSRS_ADDR_STATUS, s);
            k++;
        end while (int'(s[12:8]) < n && k < 3000);
        if (int'(s[12:8]) < n) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic drain();
        logic [31:0] s;
        for (int k = 0; k < 40; k++) begin
            rd(BSRS_ADDR_STATUS, s);
            if (s[7]) break;
            rd(BSRS_ADDR_DATA, s);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, sig_base, zero_lvl, az_seen} = '0;
        {cyc, last_t, gap, nconv, fails, checks} = '0;
        hsize  = 3'b010;
        lat    = 4'h5;
        resetn = 1'b0;
        q = $urandom(70);
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(BSRS_ADDR_CTRL, q);
        check(q, {20'h0, BSRS_CTRL_RESET});
        rd(BSRS_ADDR_SETTLE, q);
        check(q, {16'h0, BSRS_SETTLE_US_RST});
        check({31'h0, exc_10v}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        bus(1'b1, 32'h100, 32'hFFFF, q);
        bus(1'b0, 32'h100, 32'h0, q);
        check(q, 32'h0);
        // every rate code, auto-zero on the odd codes, which moves 100 per second to 50 Hz
        for (int s = 0; s < 16; s++) begin
            wr(BSRS_ADDR_CTRL, {20'h0, 4'(s), 5'h0, 1'(s), 2'h0});
            rd(BSRS_ADDR_STATUS, q);
            check(32'(q[5:4]), 32'(mains(s, 1'(s))));
            rd(BSRS_ADDR_CTRL, q);
            check(32'(q[11:8]), 32'(s));
        end
        // default settle: early conversions are dropped
        wr(BSRS_ADDR_CTRL, 32'h3);
        t0 = cyc;
        repeat (300) @(posedge sys_clk);
        rd(BSRS_ADDR_STATUS, q);
        check(32'(q[7:6]), 32'h3);
        wait_level(1);
        check(32'(cyc - t0 >= 400), 32'h1);
        wr(BSRS_ADDR_CTRL, 32'h0);
        repeat (40) @(posedge sys_clk);
        drain();
        // short settle, longer than any converter latency
        wr(BSRS_ADDR_SETTLE, 32'd20);
        sig_base <= 24'($urandom);
        lat      <= 4'(5 + $urandom % 8);
        wr(BSRS_ADDR_CTRL, 32'h3);
        wait_level(8);
        for (int i = 0; i < 8; i++) begin
            rd(BSRS_ADDR_DATA, q);
            check(q, word(sig_base + 24'((i % 4) * 16), 4'(i % 4)));
        end
        check(32'(gap), 32'(spacing(0)));
        wr(BSRS_ADDR_CTRL, 32'h13);
        rd(BSRS_ADDR_STATUS, q);
        check(32'(q[6:0] & 7'h47), 32'h40);
        check(32'(exc_10v), 32'h1);
        // fill until the buffer refuses, then drain it empty
        wait_level(BSRS_FIFO_DEPTH);
        t0 = nconv;
        repeat (100) @(posedge sys_clk);
        check(32'(nconv - t0), 32'h0);
        // stop first, or a fresh result lands while the buffer is drained
        wr(BSRS_ADDR_CTRL, 32'h0);
        for (int i = 0; i < BSRS_FIFO_DEPTH; i++) rd(BSRS_ADDR_DATA, q);
        rd(BSRS_ADDR_STATUS, q);
        check(32'(q[12:7]), 32'h1);
        rd(BSRS_ADDR_DATA, q);
        check(q, 32'h0);
        // auto-zero pairs a signal with a zero reading
        sig_base <= 24'($urandom);
        zero_lvl <= 24'($urandom);
        wr(BSRS_ADDR_CTRL, 32'h5);
        wait_level(2);
        for (int i = 0; i < 2; i++) begin
            rd(BSRS_ADDR_DATA, q);
            check(q, word(sig_base - zero_lvl, 4'h0));
        end
        // general purpose group ignores auto-zero
        wr(BSRS_ADDR_CTRL, 32'h0);
        repeat (80) @(posedge sys_clk);
        drain();
        az_seen = 1'b0;
        wr(BSRS_ADDR_CTRL, 32'h10D);
        wait_level(2);
        for (int i = 0; i < 2; i++) begin
            rd(BSRS_ADDR_DATA, q);
            check(q, word(sig_base + 24'h40, 4'h0));
        end
        check(32'(az_seen), 32'h0);
        check(32'(gap), 32'(spacing(1)));
        give_verdict();
    end
endmodule
